// *** src/float_abs_exec.sv ***
module float_abs_exec
  import fabs_pkg::*;
(
  // Clock and reset.
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave.
  input  wire logic [7:0]                    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Instruction issue from the pipeline.
  input  wire logic                          instr_valid,
  input  wire logic [31:0]                   instr_word,
  input  wire logic [fabs_pkg::ADDR_W-1:0]   ar_src,
  input  wire logic [fabs_pkg::ADDR_W-1:0]   ar_dst,
  output logic                               exec_done,
  output logic                               exec_illegal,
  // Data memory.
  output logic      [fabs_pkg::ADDR_W-1:0]   mem_rd_addr,
  input  wire logic [31:0]                   mem_rd_data,
  output logic                               mem_wr_en,
  output logic      [fabs_pkg::ADDR_W-1:0]   mem_wr_addr,
  output logic      [31:0]                   mem_wr_data,
  // Register file load and inspection.
  input  wire logic                          rf_load_en,
  input  wire logic [fabs_pkg::IDX_W-1:0]    rf_load_idx,
  input  wire logic [fabs_pkg::REG_W-1:0]    rf_load_data,
  input  wire logic [fabs_pkg::IDX_W-1:0]    rf_rd_idx,
  output logic      [fabs_pkg::REG_W-1:0]    rf_rd_data,
  // Status.
  output logic      [fabs_pkg::FLAG_W-1:0]   flag_word,
  output logic                               irq
);
  import fabs_pkg::*;

  function automatic logic [REG_W-1:0] mem_to_ext(input logic [31:0] w);
    mem_to_ext = {w[31:24], w[23:0], 8'h00};
  endfunction

  function automatic logic [31:0] ext_to_mem(input logic [REG_W-1:0] r);
    ext_to_mem = {r[REG_W-1:MAN_W], r[MAN_W-1:8]};
  endfunction

  function automatic logic [REG_W-1:0] short_to_ext(input logic [15:0] s);
    logic [7:0] e;
    e = {{4{s[15]}}, s[15:12]};
    if (s[15:12] == SHORT_ZERO) begin
      e = EXP_ZERO;
    end
    short_to_ext = {e, s[11:0], 20'h00000};
  endfunction

  logic [REG_W-1:0]  rf_reg [NREGS];
  logic [FLAG_W-1:0] flag_reg;
  logic              sat_mode_reg;
  logic [ADDR_W-1:0] idx0_reg;
  logic [ADDR_W-1:0] idx1_reg;
  logic [INT_W-1:0]  status_reg;
  logic [INT_W-1:0]  status_next;
  logic [INT_W-1:0]  mask_reg;
  logic              done_reg;
  logic              illegal_reg;
  logic              wr_en_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [31:0]       wr_data_reg;
  logic [REG_W-1:0]  rf_rd_reg;

  // Instruction decode.
  logic              is_par;
  logic              is_sgl;
  logic              exec_par;
  logic              exec_sgl;
  logic              exec;
  logic [1:0]        mode;
  logic [15:0]       sgl_src;
  logic [4:0]        sgl_dst;
  logic [IDX_W-1:0]  dst_idx;
  logic [IDX_W-1:0]  src3_idx;
  logic [7:0]        src2_fld;
  logic [7:0]        dst2_fld;
  logic [7:0]        src_ind_fld;
  logic [ADDR_W-1:0] src_ind_addr;
  logic [ADDR_W-1:0] dst_ind_addr;
  logic [REG_W-1:0]  operand;
  logic [REG_W-1:0]  mag_result;
  logic              mag_ovf;
  logic              mag_zero;
  logic [31:0]       store_word;

  assign mode     = instr_word[SGL_MODE_LSB +: 2];
  assign sgl_src  = instr_word[SGL_SRC_LSB +: 16];
  assign sgl_dst  = instr_word[SGL_DST_LSB +: 5];
  assign src3_idx = instr_word[PAR_SRC3_LSB +: IDX_W];
  assign src2_fld = instr_word[PAR_SRC2_LSB +: 8];
  assign dst2_fld = instr_word[PAR_DST2_LSB +: 8];

  assign is_par = (instr_word[PAR_OPC_LSB +: 7] == PAR_OPC)
                && (instr_word[PAR_ZERO_LSB +: 3] == 3'h0);
  assign is_sgl = (instr_word[SGL_OPC_LSB +: 9] == SGL_OPC)
                && (sgl_dst[4:3] == 2'h0)
                && ((mode != MODE_REG) || (sgl_src[15:3] == 13'h0000));
  assign exec_par = instr_valid && is_par;
  assign exec_sgl = instr_valid && is_sgl;
  assign exec     = exec_par || exec_sgl;

  assign dst_idx = exec_par ? instr_word[PAR_DST1_LSB +: IDX_W]
                            : sgl_dst[IDX_W-1:0];

  assign src_ind_fld = exec_par ? src2_fld : sgl_src[7:0];

  indirect_addr u_src_addr (
    .base           (ar_src),
    .disp_sel       (src_ind_fld[DISP_LSB +: 2]),
    .index_reg_zero (idx0_reg),
    .index_reg_one  (idx1_reg),
    .addr           (src_ind_addr)
  );

  indirect_addr u_dst_addr (
    .base           (ar_dst),
    .disp_sel       (dst2_fld[DISP_LSB +: 2]),
    .index_reg_zero (idx0_reg),
    .index_reg_one  (idx1_reg),
    .addr           (dst_ind_addr)
  );

  // The read address is live during the execute cycle.
  assign mem_rd_addr = (exec_par || mode == MODE_IND) ? src_ind_addr
                     : {8'h00, sgl_src};

  always_comb begin
    if (exec_par) begin
      operand = mem_to_ext(mem_rd_data);
    end else begin
      case (mode)
        MODE_REG: operand = rf_reg[sgl_src[IDX_W-1:0]];
        MODE_DIR: operand = mem_to_ext(mem_rd_data);
        MODE_IND: operand = mem_to_ext(mem_rd_data);
        MODE_IMM: operand = short_to_ext(sgl_src);
        default:  operand = rf_reg[sgl_src[IDX_W-1:0]];
      endcase
    end
  end

  // The saturate mode bit is deliberately not wired in here.
  float_magnitude u_mag (
    .src      (operand),
    .result   (mag_result),
    .overflow (mag_ovf),
    .is_zero  (mag_zero)
  );

  // Register file flops still hold the pre-write value this cycle.
  assign store_word = ext_to_mem(rf_reg[src3_idx]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREGS; i++) begin
        rf_reg[i] <= '0;
      end
    end else if (exec) begin
      rf_reg[dst_idx] <= mag_result;
    end else if (rf_load_en) begin
      rf_reg[rf_load_idx] <= rf_load_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_rd_reg <= '0;
    end else begin
      rf_rd_reg <= rf_reg[rf_rd_idx];
    end
  end

  // Store result is written one edge after the source was read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= 32'h00000000;
    end else begin
      wr_en_reg <= exec_par;
      if (exec_par) begin
        wr_addr_reg <= dst_ind_addr;
        wr_data_reg <= store_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg    <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      done_reg    <= exec;
      illegal_reg <= instr_valid && !exec;
    end
  end

  // APB slave, zero wait states.
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic hit;

  assign pready  = 1'b1;
  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && pwrite;
  assign apb_rd  = apb_acc && !pwrite;

  always_comb begin
    hit    = 1'b1;
    prdata = 32'h00000000;
    case (paddr)
      CTRL_OFS:   prdata[CTRL_SAT_BIT] = sat_mode_reg;
      FLAGS_OFS:  prdata[FLAG_W-1:0] = flag_reg;
      IDX0_OFS:   prdata[ADDR_W-1:0] = idx0_reg;
      IDX1_OFS:   prdata[ADDR_W-1:0] = idx1_reg;
      STATUS_OFS: prdata[INT_W-1:0] = status_reg;
      MASK_OFS:   prdata[INT_W-1:0] = mask_reg;
      default:    hit = 1'b0;
    endcase
  end

  assign pslverr = apb_acc && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sat_mode_reg <= 1'b0;
      idx0_reg     <= IR_RST;
      idx1_reg     <= IR_RST;
      mask_reg     <= MASK_RST;
    end else if (apb_wr) begin
      case (paddr)
        CTRL_OFS: sat_mode_reg <= pwdata[CTRL_SAT_BIT];
        IDX0_OFS: idx0_reg <= pwdata[ADDR_W-1:0];
        IDX1_OFS: idx1_reg <= pwdata[ADDR_W-1:0];
        MASK_OFS: mask_reg <= pwdata[INT_W-1:0];
        default:  ;
      endcase
    end
  end

  // An executing instruction wins over a software write of the flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= FLAGS_RST;
    end else if (exec) begin
      flag_reg[FLAG_Z]   <= mag_zero;
      flag_reg[FLAG_N]   <= 1'b0;
      flag_reg[FLAG_UNF] <= 1'b0;
      flag_reg[FLAG_V]   <= mag_ovf;
      flag_reg[FLAG_LOV] <= flag_reg[FLAG_LOV] | mag_ovf;
    end else if (apb_wr && paddr == FLAGS_OFS) begin
      flag_reg <= pwdata[FLAG_W-1:0];
    end
  end

  // Events set sticky bits; a read clears them, but a new event wins.
  always_comb begin
    status_next = status_reg;
    if (apb_rd && paddr == STATUS_OFS) begin
      status_next = '0;
    end
    status_next[INT_DONE]    = status_next[INT_DONE] | exec;
    status_next[INT_OVF]     = status_next[INT_OVF] | (exec && mag_ovf);
    status_next[INT_ZERO]    = status_next[INT_ZERO] | (exec && mag_zero);
    status_next[INT_ILLEGAL] = status_next[INT_ILLEGAL]
                             | (instr_valid && !exec);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign irq          = |(status_reg & mask_reg);
  assign flag_word    = flag_reg;
  assign exec_done    = done_reg;
  assign exec_illegal = illegal_reg;
  assign mem_wr_en    = wr_en_reg;
  assign mem_wr_addr  = wr_addr_reg;
  assign mem_wr_data  = wr_data_reg;
  assign rf_rd_data   = rf_rd_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ovf_saturate: assert property (
    exec && operand == {EXP_MAX, MAN_MIN}
    |=> rf_reg[$past(dst_idx)] == {EXP_MAX, MAN_MAX}
  ) else $error("overflow result not saturated");

  a_ovf_detect: assert property (
    exec |-> mag_ovf == (operand == {EXP_MAX, MAN_MIN})
  ) else $error("overflow detection wrong");

  a_zero_nuf: assert property (
    exec |=> flag_word[FLAG_Z] == $past(mag_zero)
      && !flag_word[FLAG_N] && !flag_word[FLAG_UNF]
  ) else $error("Z, N or underflow flag wrong after execute");

  a_flags_kept: assert property (
    exec |=> $stable(flag_word[FLAG_C]) && $stable(flag_word[FLAG_SUN])
  ) else $error("carry or sticky underflow changed by execute");

  a_ovf_flag: assert property (
    exec |=> flag_word[FLAG_V] == $past(mag_ovf)
  ) else $error("V flag does not follow overflow");

  a_latch_sticky: assert property (
    exec && !mag_ovf && flag_word[FLAG_LOV] |=> flag_word[FLAG_LOV]
  ) else $error("latched overflow lost");

  a_store_old: assert property (
    exec_par |=> mem_wr_en && mem_wr_data == $past(store_word)
      && mem_wr_addr == $past(dst_ind_addr)
  ) else $error("store did not use pre-write value");

  a_result_pos: assert property (
    exec && !mag_ovf |=> !rf_reg[$past(dst_idx)][MAN_W-1]
  ) else $error("magnitude result negative");

  a_irq_level: assert property (
    exec && mag_ovf
    |=> status_reg[INT_OVF] && (irq || !mask_reg[INT_OVF])
  ) else $error("overflow event not latched or irq low");

  c_par_ovf: cover property (exec_par && mag_ovf);
  c_par_hazard: cover property (exec_par && dst_idx == src3_idx);
  c_sgl_imm: cover property (exec_sgl && mode == MODE_IMM);
  c_back_to_back: cover property (exec_par ##1 exec_par);

endmodule

// *** src/fabs_pkg.sv ***
package fabs_pkg;

  localparam int EXP_W  = 8;
  localparam int MAN_W  = 32;
  localparam int REG_W  = 40;
  localparam int ADDR_W = 24;
  localparam int NREGS  = 8;
  localparam int IDX_W  = 3;

  // Instruction word layout.
  localparam logic [6:0] PAR_OPC      = 7'h64;
  localparam int         PAR_OPC_LSB  = 25;
  localparam int         PAR_DST1_LSB = 22;
  localparam int         PAR_ZERO_LSB = 19;
  localparam int         PAR_SRC3_LSB = 16;
  localparam int         PAR_DST2_LSB = 8;
  localparam int         PAR_SRC2_LSB = 0;
  localparam logic [8:0] SGL_OPC      = 9'h000;
  localparam int         SGL_OPC_LSB  = 23;
  localparam int         SGL_MODE_LSB = 21;
  localparam int         SGL_DST_LSB  = 16;
  localparam int         SGL_SRC_LSB  = 0;
  localparam int         DISP_LSB     = 3;

  // Source operand modes of the single form.
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_DIR = 2'h1;
  localparam logic [1:0] MODE_IND = 2'h2;
  localparam logic [1:0] MODE_IMM = 2'h3;

  // Indirect displacement selects.
  localparam logic [1:0] DISP_ZERO = 2'h0;
  localparam logic [1:0] DISP_ONE  = 2'h1;
  localparam logic [1:0] DISP_IDX0 = 2'h2;
  localparam logic [1:0] DISP_IDX1 = 2'h3;

  // Floating-point special values.
  localparam logic [7:0]  EXP_ZERO  = 8'h80;
  localparam logic [7:0]  EXP_MAX   = 8'h7F;
  localparam logic [31:0] MAN_MIN   = 32'h80000000;
  localparam logic [31:0] MAN_MAX   = 32'h7FFFFFFF;
  localparam logic [3:0]  SHORT_ZERO = 4'h8;

  // Bit positions in flag_word.
  localparam int FLAG_W   = 7;
  localparam int FLAG_C   = 0;
  localparam int FLAG_V   = 1;
  localparam int FLAG_Z   = 2;
  localparam int FLAG_N   = 3;
  localparam int FLAG_UNF = 4;
  localparam int FLAG_LOV = 5;
  localparam int FLAG_SUN = 6;

  // Register map, byte addresses.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] FLAGS_OFS  = 8'h04;
  localparam logic [7:0] IDX0_OFS   = 8'h08;
  localparam logic [7:0] IDX1_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS   = 8'h14;

  localparam int CTRL_SAT_BIT = 0;
  localparam int INT_W        = 4;
  localparam int INT_DONE     = 0;
  localparam int INT_OVF      = 1;
  localparam int INT_ZERO     = 2;
  localparam int INT_ILLEGAL  = 3;

  localparam logic [6:0]  FLAGS_RST = 7'h00;
  localparam logic [23:0] IR_RST    = 24'h000000;
  localparam logic [3:0]  MASK_RST  = 4'h0;

endpackage

// *** src/float_magnitude.sv ***
module float_magnitude
  import fabs_pkg::*;
(
  // Operand in extended-precision layout.
  input  wire logic [fabs_pkg::REG_W-1:0] src,
  // Magnitude and its conditions.
  output logic      [fabs_pkg::REG_W-1:0] result,
  output logic                            overflow,
  output logic                            is_zero
);

  logic [7:0]  src_exp;
  logic [31:0] src_man;

  assign src_exp = src[REG_W-1:MAN_W];
  assign src_man = src[MAN_W-1:0];

  // The most negative mantissa has no positive twin at the same exponent.
  always_comb begin
    overflow = 1'b0;
    result   = src;
    if (src_exp == EXP_ZERO) begin
      result = {EXP_ZERO, 32'h00000000};
    end else if (src_man == MAN_MIN) begin
      if (src_exp == EXP_MAX) begin
        overflow = 1'b1;
        result   = {EXP_MAX, MAN_MAX};
      end else begin
        result = {src_exp + 8'h01, 32'h00000000};
      end
    end else if (src_man[MAN_W-1]) begin
      result = {src_exp, 32'h00000000 - src_man};
    end
    is_zero = (result[REG_W-1:MAN_W] == EXP_ZERO);
  end

endmodule

// *** src/indirect_addr.sv ***
module indirect_addr
  import fabs_pkg::*;
(
  // Base pointer and displacement choice.
  input  wire logic [fabs_pkg::ADDR_W-1:0] base,
  input  wire logic [1:0]                  disp_sel,
  input  wire logic [fabs_pkg::ADDR_W-1:0] index_reg_zero,
  input  wire logic [fabs_pkg::ADDR_W-1:0] index_reg_one,
  // Effective address.
  output logic      [fabs_pkg::ADDR_W-1:0] addr
);

  always_comb begin
    case (disp_sel)
      DISP_ZERO: addr = base;
      DISP_ONE:  addr = base + 24'h000001;
      DISP_IDX0: addr = base + index_reg_zero;
      DISP_IDX1: addr = base + index_reg_one;
      default:   addr = base;
    endcase
  end

endmodule

// *** sim/fabs_mem_model.sv ***
module fabs_mem_model
  import fabs_pkg::*;
(
  // Clock.
  input  wire logic                        pclk,
  // Read port, answered within the same cycle.
  input  wire logic [fabs_pkg::ADDR_W-1:0] mem_rd_addr,
  output logic      [31:0]                 mem_rd_data,
  // Write port, taken at the rising edge.
  input  wire logic                        mem_wr_en,
  input  wire logic [fabs_pkg::ADDR_W-1:0] mem_wr_addr,
  input  wire logic [31:0]                 mem_wr_data
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] words [0:255];

  // Outside the modelled page nothing answers, so a pattern that follows
  // the address is returned instead of a stale word.
  assign mem_rd_data = (mem_rd_addr[23:8] == 16'h0000) ?
                       words[mem_rd_addr[7:0]] : ~{8'h00, mem_rd_addr};

  always @(posedge pclk) begin
    if (mem_wr_en && mem_wr_addr[23:8] == 16'h0000) begin
      words[mem_wr_addr[7:0]] <= mem_wr_data;
    end
  end
endmodule

// *** sim/float_abs_with_parallel_store_test.sv ***
module float_abs_with_parallel_store_test
  import fabs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               instr_valid = 1'b0;
  logic [31:0]        instr_word = 32'h0;
  logic [ADDR_W-1:0]  ar_src = 24'h0;
  logic [ADDR_W-1:0]  ar_dst = 24'h0;
  logic               exec_done;
  logic               exec_illegal;
  logic [ADDR_W-1:0]  mem_rd_addr;
  logic [31:0]        mem_rd_data;
  logic               mem_wr_en;
  logic [ADDR_W-1:0]  mem_wr_addr;
  logic [31:0]        mem_wr_data;
  logic               rf_load_en = 1'b0;
  logic [IDX_W-1:0]   rf_load_idx = 3'h0;
  logic [REG_W-1:0]   rf_load_data = 40'h0;
  logic [IDX_W-1:0]   rf_rd_idx = 3'h0;
  logic [REG_W-1:0]   rf_rd_data;
  logic [FLAG_W-1:0]  flag_word;
  logic               irq;
  int                 n_fail = 0;
  int                 samples_checked = 0;
  int                 cycles = 0;
  logic [39:0]        v;
  logic [31:0]        q;
  logic               err;
  logic               l_done;
  logic               l_ill;
  logic               l_wr;

  float_abs_exec i_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .instr_valid, .instr_word, .ar_src, .ar_dst,
    .exec_done, .exec_illegal, .mem_rd_addr, .mem_rd_data, .mem_wr_en,
    .mem_wr_addr, .mem_wr_data, .rf_load_en, .rf_load_idx, .rf_load_data,
    .rf_rd_idx, .rf_rd_data, .flag_word, .irq
  );

  fabs_mem_model i_mem (
    .pclk, .mem_rd_addr, .mem_rd_data, .mem_wr_en, .mem_wr_addr,
    .mem_wr_data
  );

  always #5 pclk = ~pclk;

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The run needs fewer than two hundred cycles; a hang is cut off well after.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic exec(input logic [31:0] w, input logic [23:0] s, d);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    ar_src <= s;
    ar_dst <= d;
    @(posedge pclk);
    instr_valid <= 1'b0;
    @(negedge pclk);
    l_done = exec_done;
    l_ill = exec_illegal;
    l_wr = mem_wr_en;
  endtask

  task automatic rd_rf(input logic [2:0] i);
    @(posedge pclk);
    rf_rd_idx <= i;
    @(posedge pclk);
    @(negedge pclk);
    v = rf_rd_data;
  endtask

  task automatic load(input logic [2:0] i, input logic [39:0] d);
    @(posedge pclk);
    rf_load_en <= 1'b1;
    rf_load_idx <= i;
    rf_load_data <= d;
    @(posedge pclk);
    rf_load_en <= 1'b0;
  endtask

  task automatic op(input logic [31:0] w, input logic [23:0] s,
                    input logic [2:0] dst, input logic [39:0] e);
    exec(w, s, 24'h0);
    check(l_done, 1'b1);
    rd_rf(dst);
    check(v, e);
  endtask

  function automatic logic [31:0] sgl(input logic [1:0] m,
                                      input logic [4:0] d,
                                      input logic [15:0] s);
    return {SGL_OPC, m, d, s};
  endfunction

  function automatic logic [31:0] par(input logic [2:0] d1, s3,
                                      input logic [7:0] d2, s2);
    return {PAR_OPC, d1, 3'h0, s3, d2, s2};
  endfunction

  function automatic logic [7:0] ind(input logic [1:0] disp);
    return {3'h0, disp, 3'h0};
  endfunction

  initial begin
    for (int i = 0; i < 256; i++) i_mem.words[i] = 32'h0;
    i_mem.words[8'h20] = 32'h05C00000;
    i_mem.words[8'h40] = 32'h03E00000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check(flag_word, 7'h00);
    check(irq, 1'b0);
    for (int a = 0; a < 24; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      check(q, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    check(err, 1'b1);
    $display("test reset done");
    apb(1'b1, IDX0_OFS, 32'h10);
    apb(1'b1, IDX1_OFS, 32'h05);
    load(3'd1, 40'h02F0000000);
    op(sgl(MODE_REG, 5'd2, 16'h1), 0, 3'd2, 40'h0210000000);
    op(sgl(MODE_DIR, 5'd3, 16'h20), 0, 3'd3, 40'h0540000000);
    op(sgl(MODE_IND, 5'd4, {8'h0, ind(DISP_IDX0)}), 24'h30, 3'd4,
       40'h0320000000);
    op(sgl(MODE_IMM, 5'd5, 16'h1C00), 0, 3'd5, 40'h0140000000);
    $display("test modes done");
    load(3'd3, 40'h0690000000);
    exec(par(3'd3, 3'd3, ind(DISP_IDX1), ind(DISP_ONE)), 24'h1F, 24'h50);
    check(l_wr, 1'b1);
    check(mem_wr_addr, 24'h55);
    check(mem_wr_data, 32'h06900000);
    rd_rf(3'd3);
    check(v, 40'h0540000000);
    check(i_mem.words[8'h55], 32'h06900000);
    exec(par(3'd7, 3'd5, ind(DISP_ZERO), ind(DISP_ZERO)), 24'h40, 24'h40);
    rd_rf(3'd7);
    check(v, 40'h0320000000);
    check(i_mem.words[8'h40], 32'h01400000);
    $display("test paired done");
    apb(1'b1, MASK_OFS, 32'h2);
    apb(1'b0, STATUS_OFS, 32'h0);
    apb(1'b1, FLAGS_OFS, 32'h59);
    apb(1'b1, CTRL_OFS, 32'h1);
    load(3'd0, 40'h7F80000000);
    op(sgl(MODE_REG, 5'd1, 16'h0), 0, 3'd1, 40'h7F7FFFFFFF);
    check(flag_word, 7'h63);
    check(irq, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(q, 32'h3);
    op(sgl(MODE_REG, 5'd2, 16'h1), 0, 3'd2, 40'h7F7FFFFFFF);
    check(flag_word, 7'h61);
    check(irq, 1'b0);
    load(3'd0, 40'h8000000000);
    op(sgl(MODE_REG, 5'd3, 16'h0), 0, 3'd3, 40'h8000000000);
    check(flag_word, 7'h65);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(q, 32'h5);
    $display("test flags done");
    exec(par(3'd2, 3'd0, 8'h0, 8'h0) | 32'h00080000, 0, 0);
    check(l_ill, 1'b1);
    check(l_done, 1'b0);
    exec(sgl(MODE_REG, 5'd8, 16'h0), 0, 0);
    check(l_ill, 1'b1);
    exec(32'h20000000, 0, 0);
    check(l_ill, 1'b1);
    rd_rf(3'd2);
    check(v, 40'h7F7FFFFFFF);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(q, 32'h8);
    $display("test illegal done");
    give_verdict();
  end
endmodule
